// ===== ittp_pkg.sv
// Shared constants and types for the interrupt test and priority promotion block
package ittp_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] IDX_TEST_CTRL = 8'h15;
  localparam logic [7:0] IDX_FORCE_BANK = 8'h16;
  localparam logic [7:0] IDX_STATUS = 8'h18;
  localparam logic [7:0] IDX_PROMOTE = 8'h1F;
  localparam logic [7:0] ADDR_TEST_CTRL = 8'(IDX_TEST_CTRL * 4);
  localparam logic [7:0] ADDR_FORCE_BANK = 8'(IDX_FORCE_BANK * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
  localparam logic [7:0] ADDR_PROMOTE = 8'(IDX_PROMOTE * 4);

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int CTRL_WRT_BIT = 4;
  localparam int SEL_W = 4;
  localparam int STAT_PEND_BIT = 8;
  localparam int STAT_WAKE_BIT = 9;
  localparam int NUM_REQ = 128;
  localparam logic [3:0] BANK_TOP = 4'hF;
  localparam logic [7:0] TOP_BANK_MASK = 8'h07;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [7:0] PROMOTE_RST = 8'hF2;

  // ****************************************************************
  // Vector low bytes and slot indices, high byte is always the same
  // ****************************************************************
  localparam logic [7:0] VEC_HIGH = 8'hFF;
  localparam logic [7:0] VEC_SYS_RST = 8'hFE;
  localparam logic [7:0] VEC_XTAL_RST = 8'hFC;
  localparam logic [7:0] VEC_WDOG_RST = 8'hFA;
  localparam logic [7:0] VEC_TRAP = 8'hF8;
  localparam logic [7:0] VEC_SWI = 8'hF6;
  localparam logic [7:0] VEC_NMI_PIN = 8'hF4;
  localparam logic [6:0] IDX_MASK_PIN = 7'h79;
  localparam logic [6:0] IDX_NMI_PIN = 7'h7A;

  // ****************************************************************
  // Bus answers, states and carriers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ITTP_BUS_IDLE = 2'b00,
    ITTP_BUS_RESP = 2'b01
  } ittp_bus_st_t;

  typedef struct packed {
    logic wrt;
    logic [SEL_W-1:0] sel;
  } ittp_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [6:0] idx;
  } ittp_pick_t;

endpackage : ittp_pkg

// ===== ittp_force_bank.sv
// Bank of forced-request registers, one byte per group of eight vectors
`timescale 1ns/1ns
`default_nettype none
module ittp_force_bank
  import ittp_pkg::*;
#(
  parameter int NUM_BANKS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic [7:0] wdata_i,
  output logic [NUM_BANKS*8-1:0] force_o,
  output logic [7:0] rd_byte_o
);

  logic [7:0] bank_r [NUM_BANKS];
  logic [7:0] bank_nxt [NUM_BANKS];

  // ****************************************************************
  // One byte per bank, cleared by reset so no forced request survives
  // ****************************************************************
  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    always_comb begin
      bank_nxt[g] = bank_r[g];
      if (we_i && (sel_i == SEL_W'(g))) begin
        bank_nxt[g] = wdata_i;
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bank_r[g] <= 8'h00;
      end else begin
        bank_r[g] <= bank_nxt[g];
      end
    end
    assign force_o[g*8 +: 8] = bank_r[g];
  end

  // Selected bank for readback
  assign rd_byte_o = bank_r[sel_i];

endmodule : ittp_force_bank
`default_nettype wire

// ===== ittp_prio_pick.sv
// Picks the highest vector index among a set of request bits
`timescale 1ns/1ns
`default_nettype none
module ittp_prio_pick
  import ittp_pkg::*;
#(
  parameter int WIDTH = NUM_REQ
) (
  input wire logic [WIDTH-1:0] req_i,
  output ittp_pick_t pick_o
);

  // Ascending scan, so the last set bit (highest vector) wins
  always_comb begin
    pick_o = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (req_i[i]) begin
        pick_o.valid = 1'b1;
        pick_o.idx = 7'(i);
      end
    end
  end

endmodule : ittp_prio_pick
`default_nettype wire

// ===== ittp_top.sv
// Interrupt test bank, priority promotion, vector answer and wake-up path
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ittp_top
  import ittp_pkg::*;
#(
  parameter logic [3:0] MIN_BANK = 4'h0
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SPECIAL_MODE_I,
  input wire logic I_MASK_I,
  input wire logic X_MASK_I,
  input wire logic [NUM_REQ-1:0] IRQ_REQ_I,
  input wire logic NMI_PIN_REQ_I,
  input wire logic RST_SYS_REQ_I,
  input wire logic RST_XTAL_REQ_I,
  input wire logic RST_WDOG_REQ_I,
  input wire logic TRAP_REQ_I,
  input wire logic SWI_REQ_I,
  input wire logic VEC_REQ_I,
  output logic [15:0] VEC_O,
  output logic VEC_VALID_O,
  output logic INT_PENDING_O,
  output logic WAKE_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ittp_bus_st_t wr_st_r, wr_st_nxt, rd_st_r, rd_st_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  ittp_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] promote_r, promote_nxt;
  logic [7:0] last_vec_r, last_vec_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic vec_valid_r, vec_valid_nxt;
  logic do_wr;
  logic force_we;
  logic [7:0] force_wdata, force_rd, live_rd, test_rd, bank_mask;
  logic bank_impl;
  logic [NUM_REQ-1:0] impl_mask, live_req, force_req, eff_req, icand;
  logic eff_nmi, nmi_valid, prom_ok, prom_hit;
  logic [6:0] prom_idx;
  ittp_pick_t pick;
  logic [7:0] sel_vec;
  logic pend_any;

  // ****************************************************************
  // Request routing
  // ****************************************************************
  // Implemented vector slots: banks from MIN_BANK up to the nonmaskable pin
  for (genvar i = 0; i < NUM_REQ; i++) begin : g_impl
    assign impl_mask[i] = (7'(i) <= IDX_NMI_PIN) && (4'(i / 8) >= MIN_BANK);
    assign live_req[i] = (7'(i) == IDX_NMI_PIN) ? NMI_PIN_REQ_I
                       : (IRQ_REQ_I[i] & impl_mask[i]);
  end

  // Forcing replaces the inputs wholesale; mixing both would hide decoder faults
  assign eff_req = ctrl_r.wrt ? (force_req & impl_mask) : live_req;
  assign eff_nmi = eff_req[IDX_NMI_PIN];
  assign nmi_valid = eff_nmi & ~X_MASK_I;

  // Maskable candidates, everything below the nonmaskable pin slot
  always_comb begin
    icand = eff_req & impl_mask & {NUM_REQ{~I_MASK_I}};
    icand[IDX_NMI_PIN] = 1'b0;
  end

  ittp_prio_pick #(
    .WIDTH(NUM_REQ)
  ) u_pick (
    .req_i(icand),
    .pick_o(pick)
  );

  // ****************************************************************
  // Promotion of one maskable source
  // ****************************************************************
  // Promote field holds the vector low byte; shifted down one bit it gives the index
  assign prom_ok = impl_mask[promote_r[7:1]] && (promote_r[7:1] <= IDX_MASK_PIN);
  assign prom_idx = prom_ok ? promote_r[7:1] : IDX_MASK_PIN;
  assign prom_hit = icand[prom_idx];

  // Fixed priority chain down to the maskable sources
  always_comb begin
    pend_any = 1'b1;
    sel_vec = VEC_SWI;
    if (RST_SYS_REQ_I) begin
      sel_vec = VEC_SYS_RST;
    end else if (RST_XTAL_REQ_I) begin
      sel_vec = VEC_XTAL_RST;
    end else if (RST_WDOG_REQ_I) begin
      sel_vec = VEC_WDOG_RST;
    end else if (TRAP_REQ_I) begin
      sel_vec = VEC_TRAP;
    end else if (SWI_REQ_I) begin
      sel_vec = VEC_SWI;
    end else if (nmi_valid) begin
      sel_vec = VEC_NMI_PIN;
    end else if (prom_hit) begin
      sel_vec = {prom_idx, 1'b0};
    end else if (pick.valid) begin
      sel_vec = {pick.idx, 1'b0};
    end else begin
      pend_any = 1'b0;
    end
  end

  // ****************************************************************
  // Vector answer to the CPU
  // ****************************************************************
  // Decided at request time, so a later higher request does not override the cause
  always_comb begin
    last_vec_nxt = pend_any ? sel_vec : last_vec_r;
    vec_nxt = vec_r;
    vec_valid_nxt = 1'b0;
    if (VEC_REQ_I) begin
      vec_nxt = pend_any ? sel_vec : last_vec_r;
      vec_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      last_vec_r <= VEC_SWI;
      vec_r <= VEC_SWI;
      vec_valid_r <= 1'b0;
    end else begin
      last_vec_r <= last_vec_nxt;
      vec_r <= vec_nxt;
      vec_valid_r <= vec_valid_nxt;
    end
  end

  assign VEC_O = {VEC_HIGH, vec_r};
  assign VEC_VALID_O = vec_valid_r;
  assign INT_PENDING_O = pend_any;

  // No flops on this path: it must work with the clock stopped
  assign WAKE_O = (|icand) | nmi_valid | eff_nmi | NMI_PIN_REQ_I;

  // ****************************************************************
  // Test bank access
  // ****************************************************************
  assign bank_impl = (ctrl_r.sel >= MIN_BANK);
  assign bank_mask = (ctrl_r.sel == BANK_TOP) ? TOP_BANK_MASK : FULL_MASK;
  assign live_rd = live_req[{ctrl_r.sel, 3'b000} +: 8];

  always_comb begin
    test_rd = 8'h00;
    if (SPECIAL_MODE_I && bank_impl) begin
      test_rd = (ctrl_r.wrt ? force_rd : live_rd) & bank_mask;
    end
  end

  assign force_we = do_wr && wlane_r && (awaddr_r == ADDR_FORCE_BANK) && SPECIAL_MODE_I
                 && ctrl_r.wrt && I_MASK_I && bank_impl;
  assign force_wdata = wbyte_r & bank_mask;

  ittp_force_bank #(
    .NUM_BANKS(NUM_REQ / 8)
  ) u_bank (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .we_i(force_we),
    .sel_i(ctrl_r.sel),
    .wdata_i(force_wdata),
    .force_o(force_req),
    .rd_byte_o(force_rd)
  );

  // ****************************************************************
  // Control and promotion registers
  // ****************************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    promote_nxt = promote_r;
    if (do_wr && wlane_r) begin
      if (awaddr_r == ADDR_TEST_CTRL) begin
        ctrl_nxt.sel = wbyte_r[SEL_W-1:0];
        if (SPECIAL_MODE_I && I_MASK_I && X_MASK_I) begin
          ctrl_nxt.wrt = wbyte_r[CTRL_WRT_BIT];
        end
      end else if ((awaddr_r == ADDR_PROMOTE) && I_MASK_I) begin
        promote_nxt = {wbyte_r[7:1], 1'b0};
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ctrl_r <= '0;
      promote_r <= PROMOTE_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      promote_r <= promote_nxt;
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are parked independently; the write lands once both are in
  assign S_AXI_AWREADY_O = ~aw_held_r && (wr_st_r == ITTP_BUS_IDLE);
  assign S_AXI_WREADY_O = ~w_held_r && (wr_st_r == ITTP_BUS_IDLE);
  assign do_wr = aw_held_r && w_held_r && (wr_st_r == ITTP_BUS_IDLE);

  always_comb begin
    wr_st_nxt = wr_st_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bresp_nxt = bresp_r;
    case (wr_st_r)
      ITTP_BUS_IDLE: begin
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
          aw_held_nxt = 1'b1;
          awaddr_nxt = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
          w_held_nxt = 1'b1;
          wbyte_nxt = S_AXI_WDATA_I[7:0];
          wlane_nxt = S_AXI_WSTRB_I[0];
        end
        if (do_wr) begin
          aw_held_nxt = 1'b0;
          w_held_nxt = 1'b0;
          wr_st_nxt = ITTP_BUS_RESP;
          if ((awaddr_r == ADDR_TEST_CTRL) || (awaddr_r == ADDR_FORCE_BANK)
              || (awaddr_r == ADDR_STATUS) || (awaddr_r == ADDR_PROMOTE)) begin
            bresp_nxt = RESP_OKAY;
          end else begin
            bresp_nxt = RESP_SLVERR;
          end
        end
      end
      ITTP_BUS_RESP: begin
        if (S_AXI_BREADY_I) begin
          wr_st_nxt = ITTP_BUS_IDLE;
        end
      end
      default: begin
        wr_st_nxt = ITTP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      wr_st_r <= ITTP_BUS_IDLE;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      wr_st_r <= wr_st_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  assign S_AXI_BVALID_O = (wr_st_r == ITTP_BUS_RESP);
  assign S_AXI_BRESP_O = bresp_r;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign S_AXI_ARREADY_O = (rd_st_r == ITTP_BUS_IDLE);

  always_comb begin
    rd_st_nxt = rd_st_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_st_r)
      ITTP_BUS_IDLE: begin
        if (S_AXI_ARVALID_I) begin
          rd_st_nxt = ITTP_BUS_RESP;
          rresp_nxt = RESP_OKAY;
          rdata_nxt = 32'h0000_0000;
          if (S_AXI_ARADDR_I == ADDR_TEST_CTRL) begin
            rdata_nxt[CTRL_WRT_BIT:0] = ctrl_r;
          end else if (S_AXI_ARADDR_I == ADDR_FORCE_BANK) begin
            rdata_nxt[7:0] = test_rd;
          end else if (S_AXI_ARADDR_I == ADDR_STATUS) begin
            rdata_nxt[7:0] = sel_vec;
            rdata_nxt[STAT_PEND_BIT] = pend_any;
            rdata_nxt[STAT_WAKE_BIT] = WAKE_O;
          end else if (S_AXI_ARADDR_I == ADDR_PROMOTE) begin
            rdata_nxt[7:0] = promote_r;
          end else begin
            rresp_nxt = RESP_SLVERR;
          end
        end
      end
      ITTP_BUS_RESP: begin
        if (S_AXI_RREADY_I) begin
          rd_st_nxt = ITTP_BUS_IDLE;
        end
      end
      default: begin
        rd_st_nxt = ITTP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rd_st_r <= ITTP_BUS_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      rd_st_r <= rd_st_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign S_AXI_RVALID_O = (rd_st_r == ITTP_BUS_RESP);
  assign S_AXI_RDATA_O = rdata_r;
  assign S_AXI_RRESP_O = rresp_r;

endmodule : ittp_top
`default_nettype wire

// ===== ittp_top_asserts.sv
// Concurrent checks on the interrupt test and priority promotion block ports
`timescale 1ns/1ns
`default_nettype none
module ittp_chk
  import ittp_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic SPECIAL_MODE_I,
  input wire logic NMI_PIN_REQ_I,
  input wire logic RST_SYS_REQ_I,
  input wire logic RST_XTAL_REQ_I,
  input wire logic RST_WDOG_REQ_I,
  input wire logic TRAP_REQ_I,
  input wire logic VEC_REQ_I,
  input wire logic [15:0] VEC_O,
  input wire logic VEC_VALID_O,
  input wire logic INT_PENDING_O,
  input wire logic WAKE_O
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  // Steps of a vector fetch and of a register write
  sequence s_vec_ask;
    VEC_REQ_I;
  endsequence
  sequence s_wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  property p_vec_ans;
    s_vec_ask |=> VEC_VALID_O;
  endproperty
  property p_vec_hold;
    !VEC_REQ_I |=> $stable(VEC_O);
  endproperty
  property p_sys;
    VEC_REQ_I && RST_SYS_REQ_I |=> VEC_O == {VEC_HIGH, VEC_SYS_RST};
  endproperty
  property p_xtal;
    VEC_REQ_I && !RST_SYS_REQ_I && RST_XTAL_REQ_I |=> VEC_O == {VEC_HIGH, VEC_XTAL_RST};
  endproperty
  // Trap only wins once every reset request is quiet
  property p_trap;
    VEC_REQ_I && TRAP_REQ_I && !(RST_SYS_REQ_I || RST_XTAL_REQ_I || RST_WDOG_REQ_I)
      |=> VEC_O == {VEC_HIGH, VEC_TRAP};
  endproperty
  property p_wake;
    NMI_PIN_REQ_I |-> WAKE_O;
  endproperty
  property p_pend;
    RST_SYS_REQ_I || TRAP_REQ_I |-> INT_PENDING_O;
  endproperty
  property p_rd_zero;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == ADDR_FORCE_BANK && !SPECIAL_MODE_I
      |=> S_AXI_RDATA_O == 32'h0000_0000;
  endproperty
  property p_wr_ans;
    s_wr_taken |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O;
  endproperty
  a_vec_ans: assert property (p_vec_ans) else $error("vector answer missing");
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved unasked");
  a_sys: assert property (p_sys) else $error("system reset vector wrong");
  a_xtal: assert property (p_xtal) else $error("crystal reset vector wrong");
  a_trap: assert property (p_trap) else $error("trap vector wrong");
  a_wake: assert property (p_wake) else $error("no wake on pin request");
  a_pend: assert property (p_pend) else $error("pending flag low");
  a_rd_zero: assert property (p_rd_zero) else $error("test read not zero");
  a_wr_ans: assert property (p_wr_ans) else $error("write answer timing");
endmodule : ittp_chk

bind ittp_top ittp_chk u_chk (
  .CORE_CLK_I, .RST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I,
  .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
  .S_AXI_RDATA_O, .SPECIAL_MODE_I, .NMI_PIN_REQ_I, .RST_SYS_REQ_I, .RST_XTAL_REQ_I,
  .RST_WDOG_REQ_I, .TRAP_REQ_I, .VEC_REQ_I, .VEC_O, .VEC_VALID_O, .INT_PENDING_O, .WAKE_O
);
`default_nettype wire

// ===== ittp_cpu_model.sv
// Behavioural core model: reset cause decode and paced vector requests
`timescale 1ns/1ns
`default_nettype none
module ittp_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [3:0] dly_i,
  input wire logic [1:0] cause_i,
  output logic vec_req_o,
  output var logic [2:0] rst_req_o
);
  logic [4:0] cnt_r;
  // One request line per decoded cause, so two resets never overlap
  assign rst_req_o = {cause_i == 2'h1, cause_i == 2'h2, cause_i == 2'h3};
  // Delay lets the core ask promptly or late; request lasts one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
      vec_req_o <= 1'b0;
    end else begin
      vec_req_o <= (cnt_r == 5'h01);
      if (go_i) begin
        cnt_r <= {1'b0, dly_i} + 5'h01;
      end else if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end
endmodule : ittp_cpu_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the interrupt test and priority promotion block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import ittp_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, spec = 1'b0, imask = 1'b1, xmask = 1'b1;
  logic nmi = 1'b0, trap = 1'b0, software_interrupt = 1'b0, go = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, vvalid, pend, wake, vreq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [127:0] irq = 128'h0;
  logic [3:0] dly = 4'h0;
  logic [1:0] cause = 2'h0, bresp, rresp;
  logic [2:0] rreq;
  logic [15:0] vec;
  logic [33:0] exp_q[$];
  logic [7:0] lad [8] = '{8'hFE, 8'hFC, 8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hF2};
  int n_errors = 0, compares = 0;

  ittp_top #(.MIN_BANK(4'h1)) dut (
    .CORE_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .SPECIAL_MODE_I(spec), .I_MASK_I(imask), .X_MASK_I(xmask), .IRQ_REQ_I(irq),
    .NMI_PIN_REQ_I(nmi), .RST_SYS_REQ_I(rreq[2]), .RST_XTAL_REQ_I(rreq[1]),
    .RST_WDOG_REQ_I(rreq[0]), .TRAP_REQ_I(trap), .SWI_REQ_I(software_interrupt), .VEC_REQ_I(vreq),
    .VEC_O(vec), .VEC_VALID_O(vvalid), .INT_PENDING_O(pend), .WAKE_O(wake));
  ittp_cpu_model cpu (.clk_i(clk), .rst_i(rst), .go_i(go), .dly_i(dly), .cause_i(cause),
    .vec_req_o(vreq), .rst_req_o(rreq));

  // ********************
  // Clock, checking and bus tasks
  // ********************
  always #4 clk = ~clk;
  // Results are matched to notes in order; bus and vector never overlap
  always @(posedge clk) begin
    if (vvalid) take({18'h0_0000, vec});
    if (rvalid && rready) take({rresp, rdata});
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, got, want);
    end
  endtask : chk
  task automatic take(input logic [33:0] got);
    logic [33:0] want;
    want = 'x;
    if (exp_q.size() > 0) want = exp_q.pop_front();
    chk(got, want);
  endtask : take
  task automatic wrap_up;
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // Every wait is bounded; running out counts as a mismatch
  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 300) begin
      n_errors++;
      wrap_up();
    end
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    int n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel is released at its own handshake, in whatever order they come
    do begin
      step(n);
      aw_done = aw_done | awready;
      w_done = w_done | wready;
      if (aw_done) begin
        awvalid <= 1'b0;
      end
      if (w_done) begin
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do step(n); while (!bvalid);
    bready <= 1'b0;
    chk({32'h0000_0000, bresp}, {32'h0000_0000, resp});
    // One idle edge, so the next call never re-raises bready in this time step
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
    int n;
    n = 0;
    exp_q.push_back({resp, 24'h00_0000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (!arready);
    arvalid <= 1'b0;
    do step(n); while (!rvalid);
    rready <= 1'b0;
    // One idle edge, so the next call never re-raises rready in this time step
    @(posedge clk);
  endtask : rd
  // Core asks for a vector after a random pause
  task automatic vq(input logic [7:0] lo);
    int n;
    n = 0;
    exp_q.push_back({18'h0_0000, VEC_HIGH, lo});
    dly <= 4'($urandom % 6);
    go <= 1'b1;
    step(n);
    go <= 1'b0;
    do step(n); while (!vvalid);
  endtask : vq

  // ********************
  // Main sequence
  // ********************
  initial begin
    int i;
    logic [7:0] b;
    i = $urandom(73527);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    vq(VEC_SWI);
    // Nothing pending: status shows the default vector, pending and wake low
    rd(ADDR_STATUS, VEC_SWI, RESP_OKAY);
    rd(ADDR_PROMOTE, PROMOTE_RST, RESP_OKAY);
    rd(8'h00, 8'h00, RESP_SLVERR);
    wr(8'h04, 8'h55, RESP_SLVERR);
    wr(ADDR_TEST_CTRL, 8'h05, RESP_OKAY);
    irq <= {$urandom, $urandom, $urandom, $urandom};
    rd(ADDR_FORCE_BANK, 8'h00, RESP_OKAY);
    spec <= 1'b1;
    nmi <= 1'b1;
    // Live view of every group; group 0 is not built in this instance
    for (i = 0; i < 16; i++) begin
      wr(ADDR_TEST_CTRL, 8'(i), RESP_OKAY);
      b = (i == 0) ? 8'h00 : (i == 15) ? {5'h00, 1'b1, irq[121:120]} : irq[8*i +: 8];
      rd(ADDR_FORCE_BANK, b, RESP_OKAY);
    end
    wr(ADDR_TEST_CTRL, 8'h13, RESP_OKAY);
    imask <= 1'b0;
    wr(ADDR_FORCE_BANK, 8'hFF, RESP_OKAY);
    rd(ADDR_FORCE_BANK, 8'h00, RESP_OKAY);
    imask <= 1'b1;
    wr(ADDR_FORCE_BANK, 8'h20, RESP_OKAY);
    rd(ADDR_FORCE_BANK, 8'h20, RESP_OKAY);
    wr(ADDR_TEST_CTRL, 8'h1F, RESP_OKAY);
    wr(ADDR_FORCE_BANK, 8'hFF, RESP_OKAY);
    rd(ADDR_FORCE_BANK, 8'h07, RESP_OKAY);
    wr(ADDR_FORCE_BANK, 8'h00, RESP_OKAY);
    wr(ADDR_TEST_CTRL, 8'h10, RESP_OKAY);
    wr(ADDR_FORCE_BANK, 8'hFF, RESP_OKAY);
    rd(ADDR_FORCE_BANK, 8'h00, RESP_OKAY);
    // Every live line asserted, yet only the one forced bit may win
    irq <= ~128'h0;
    imask <= 1'b0;
    vq(8'h3A);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    imask <= 1'b1;
    @(posedge clk);
    wr(ADDR_TEST_CTRL, 8'h13, RESP_OKAY);
    rd(ADDR_FORCE_BANK, 8'h00, RESP_OKAY);
    wr(ADDR_TEST_CTRL, 8'h03, RESP_OKAY);
    spec <= 1'b0;
    imask <= 1'b0;
    wr(ADDR_PROMOTE, 8'h20, RESP_OKAY);
    rd(ADDR_PROMOTE, PROMOTE_RST, RESP_OKAY);
    imask <= 1'b1;
    wr(ADDR_PROMOTE, 8'h20, RESP_OKAY);
    rd(ADDR_PROMOTE, 8'h20, RESP_OKAY);
    irq <= (128'h1 << 16) | (128'h1 << 56);
    imask <= 1'b0;
    vq(8'h20);
    imask <= 1'b1;
    wr(ADDR_PROMOTE, 8'h04, RESP_OKAY);
    irq <= irq | (128'h1 << 2) | (128'h1 << 121);
    imask <= 1'b0;
    vq(8'hF2);
    nmi <= 1'b0;
    @(posedge clk);
    chk({33'h0, wake}, 34'h1);
    imask <= 1'b1;
    @(posedge clk);
    chk({33'h0, wake}, 34'h0);
    nmi <= 1'b1;
    @(posedge clk);
    chk({33'h0, wake}, 34'h1);
    // Drop sources from the top down; the last step has nothing pending
    xmask <= 1'b0;
    for (i = 0; i < 8; i++) begin
      cause <= (i < 3) ? 2'(i + 1) : 2'h0;
      trap <= (i < 4);
      software_interrupt <= (i < 5);
      nmi <= (i < 6);
      imask <= (i > 6);
      vq(lad[i]);
      chk({33'h0, pend}, {33'h0, i < 7});
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
